/* dv/scpb_port_bank_chk.sv */
// Purpose: Assertions on the ports of the system control port bank.
// Assumes: One clock domain with resetn as its asynchronous reset.
// Notes:   Bound to the top module below the module.
`timescale 1ns/1ps
`default_nettype none
module scpb_port_bank_chk
  import scpb_pkg::*;
#(
  parameter int OP_CYCLES = NVM_OP_CYCLES
) (
  // Clock and reset.
  input wire logic             clock,
  input wire logic             resetn,
  // Bus side.
  input wire scpb_bus_req_type busReq,
  input wire logic [15:0]      rdData_ff,
  input wire logic             rdValid_ff,
  input wire logic             accessReject_ff,
  input wire logic             eccSingleErr,
  input wire logic             eccDoubleErr,
  // Controlled outputs.
  input wire logic             mainCpuHalt_ff,
  input wire logic             protocolCpuResetn_ff,
  input wire logic [15:0]      analogTrimBankA_ff,
  input wire logic [15:0]      analogTrimBankB_ff,
  input wire logic [15:0]      analogTrimBankC_ff,
  input wire logic             nvmBusyFlag_ff,
  input wire logic             nvmDoneInterrupt_ff,
  input wire logic             nvmProtectInterrupt_ff
);
  logic acc;
  logic sysSp;
  logic usrSp;
  logic nvmSp;
  logic ctlWr;
  logic trimAw;

  assign acc    = busReq.wr | busReq.rd;
  assign sysSp  = busReq.addr >= SYS_BASE &&
                  busReq.addr < SYS_BASE + SYS_BYTES + 16'(CUSTOM_SYS_BYTES);
  assign usrSp  = busReq.addr >= USER_BASE &&
                  busReq.addr < USER_BASE + USER_BYTES + 16'(CUSTOM_USER_BYTES);
  assign nvmSp  = busReq.addr >= NVM_BASE && busReq.addr < NVM_BASE + NVM_BYTES;
  assign ctlWr  = busReq.wr && !busReq.userMode && busReq.addr == REG_SYSTEM_CONTROL;
  assign trimAw = {busReq.addr[15:1], 1'b0} == REG_TRIM_A_LOW;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_RD_LATENCY: assert property (busReq.rd && sysSp && !busReq.userMode
    |-> ##2 (rdValid_ff && rdData_ff[15:8] == 8'h00)) else $error("system read not answered");
  AST_SYS_REJECT: assert property (acc && sysSp && busReq.userMode |=> accessReject_ff)
    else $error("user access to system space not rejected");
  AST_USR_REJECT: assert property (acc && usrSp && !busReq.userMode |=> accessReject_ff)
    else $error("system access to user space not rejected");
  AST_REJ_CAUSE: assert property (accessReject_ff |-> $past(acc &&
    (sysSp ? busReq.userMode : (usrSp && !busReq.userMode)))) else $error("reject without cause");
  AST_HALT_SET: assert property (ctlWr && busReq.wdata[CTL_HALT_BIT] |=> mainCpuHalt_ff)
    else $error("halt not set");
  AST_HALT_HOLD: assert property (mainCpuHalt_ff |=> mainCpuHalt_ff)
    else $error("halt dropped");
  AST_PCPU_RESET: assert property (ctlWr |-> ##2
    (protocolCpuResetn_ff == $past(busReq.wdata[CTL_PCPU_RESET_BIT], 2))) else $error("pcpu reset");
  AST_TRIM_A_CAUSE: assert property ($changed(analogTrimBankA_ff)
    |-> $past(busReq.wr && !busReq.userMode && trimAw, 2)) else $error("trim bank a changed");
  AST_TRIM_B_CAUSE: assert property ($changed(analogTrimBankB_ff)
    |-> $past(busReq.wr && !busReq.userMode &&
              {busReq.addr[15:1], 1'b0} == REG_TRIM_A_LOW + 16'h0002, 2))
    else $error("trim bank b changed");
  AST_TRIM_C_CAUSE: assert property ($changed(analogTrimBankC_ff)
    |-> $past(busReq.wr && !busReq.userMode &&
              {busReq.addr[15:1], 1'b0} == REG_TRIM_A_LOW + 16'h0004, 2))
    else $error("trim bank c changed");
  AST_BUSY_CAUSE: assert property ($rose(nvmBusyFlag_ff)
    |-> $past(busReq.wr && nvmSp && !busReq.userMode)) else $error("busy without write");
  AST_DONE_PULSE: assert property (nvmDoneInterrupt_ff == $fell(nvmBusyFlag_ff))
    else $error("done pulse not at busy fall");
  AST_PROT_CAUSE: assert property (nvmProtectInterrupt_ff |-> $past(acc && nvmSp))
    else $error("protect pulse without memory access");
endmodule

bind scpb_system_control_port_bank scpb_port_bank_chk #(.OP_CYCLES(OP_CYCLES)) uChk (
  .clock(clock), .resetn(resetn), .busReq(busReq), .rdData_ff(rdData_ff),
  .rdValid_ff(rdValid_ff), .accessReject_ff(accessReject_ff), .eccSingleErr(eccSingleErr),
  .eccDoubleErr(eccDoubleErr), .mainCpuHalt_ff(mainCpuHalt_ff),
  .protocolCpuResetn_ff(protocolCpuResetn_ff), .analogTrimBankA_ff(analogTrimBankA_ff),
  .analogTrimBankB_ff(analogTrimBankB_ff), .analogTrimBankC_ff(analogTrimBankC_ff),
  .nvmBusyFlag_ff(nvmBusyFlag_ff), .nvmDoneInterrupt_ff(nvmDoneInterrupt_ff),
  .nvmProtectInterrupt_ff(nvmProtectInterrupt_ff));
`default_nettype wire

/* dv/scpb_system_control_port_bank_tb.sv */
// Purpose: Self-checking bench of the system control port bank.
// Assumes: Operation delay shortened through OP_CYCLES.
// Notes:   Each scenario drives the bus and judges the ports.
`timescale 1ns/1ps
`default_nettype none
module scpb_system_control_port_bank_tb
  import scpb_pkg::*;
;
  localparam int OPC = 120;
  logic             clock = 1'b0;
  logic             resetn = 1'b0;
  scpb_bus_req_type busReq = '0;
  logic             eccS = 1'b0;
  logic             eccD = 1'b0;
  logic [15:0]      rdData;
  logic [15:0]      trimA;
  logic [15:0]      trimB;
  logic [15:0]      trimC;
  logic             rdValid;
  logic             rej;
  logic             halt;
  logic             pcpuRstn;
  logic             busy;
  logic             done;
  logic             prot;
  logic [15:0]      rv;
  logic             rj;
  logic             pj;
  logic [15:0]      mem [NVM_WORDS];
  int               n_errors = 0;
  int               cmp_count = 0;
  int               cycles = 0;
  int               runLen = 0;
  int               lastRun = 0;

  always #4 clock = ~clock;

  scpb_system_control_port_bank #(.OP_CYCLES(OPC)) dut (
    .clock(clock), .resetn(resetn), .busReq(busReq), .rdData_ff(rdData),
    .rdValid_ff(rdValid), .accessReject_ff(rej), .eccSingleErr(eccS), .eccDoubleErr(eccD),
    .mainCpuHalt_ff(halt), .protocolCpuResetn_ff(pcpuRstn), .analogTrimBankA_ff(trimA),
    .analogTrimBankB_ff(trimB), .analogTrimBankC_ff(trimC), .nvmBusyFlag_ff(busy),
    .nvmDoneInterrupt_ff(done), .nvmProtectInterrupt_ff(prot));

  task automatic results;
    $display("counts: %0d comparisons, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Busy run length and hang guard.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) begin
      runLen <= runLen + 1;
    end else if (runLen != 0) begin
      lastRun <= runLen;
      runLen <= 0;
    end
    if (cycles == 6000) begin
      n_errors++;
      $display("mismatch at %0t: timeout", $time);
      results;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // One bus request; reject and protect flags are taken one cycle after it.
  task automatic acc(input logic [15:0] a, input logic [15:0] d, input logic w, input logic um);
    @(posedge clock);
    busReq <= '{addr: a, wdata: d, wr: w, rd: !w, userMode: um};
    @(posedge clock);
    busReq.wr <= 1'b0;
    busReq.rd <= 1'b0;
    #1;
    rj = rej;
    pj = prot;
    rv = 16'h0000;
    if (!w) begin
      @(posedge clock);
      #1;
      rv = (rdValid === 1'b1) ? rdData : 16'h0000;
    end
  endtask

  task automatic t_reset;
    acc(REG_SYSTEM_CONTROL, 16'h0000, 1'b0, 1'b0);
    chk(rv, {8'h00, CONTROL_RESET}, "control reset");
    acc(REG_NVM_CONTROL, 16'h0000, 1'b0, 1'b0);
    chk(rv, {14'h0000, NVM_OP_RESET}, "nvm control reset");
    chkb(busy, 1'b0, "busy reset");
    $display("test reset done");
  endtask

  task automatic t_modes;
    acc(REG_SYSTEM_CONTROL, 16'h0078, 1'b1, 1'b1);
    chkb(rj, 1'b1, "user write rejected");
    acc(REG_SYSTEM_CONTROL, 16'h0000, 1'b0, 1'b1);
    chkb(rj, 1'b1, "user read rejected");
    chk(rv, 16'h0000, "user read data");
    acc(REG_SYSTEM_CONTROL, 16'h0000, 1'b0, 1'b0);
    chk(rv, 16'h0000, "control untouched");
    acc(REG_USER_STATUS_FLAGS, 16'h0000, 1'b0, 1'b0);
    chkb(rj, 1'b1, "system read of user space");
    acc(REG_USER_STATUS_FLAGS, 16'h0000, 1'b0, 1'b1);
    chkb(rj, 1'b0, "user read of user space");
    $display("test modes done");
  endtask

  task automatic t_custom;
    logic [15:0] ca [4] = '{CUSTOM_SYS_BASE, CUSTOM_SYS_BASE + 16'(CUSTOM_SYS_BYTES - 1),
                            CUSTOM_USER_BASE, CUSTOM_USER_BASE + 16'(CUSTOM_USER_BYTES - 1)};
    for (int i = 0; i < 4; i++) begin
      acc(ca[i], 16'h00ff, 1'b1, i[1]);
      acc(ca[i], 16'h0000, 1'b0, i[1]);
      chk(rv, 16'h0000, "custom read");
      chkb(rj, 1'b0, "custom reject");
    end
    $display("test custom done");
  endtask

  task automatic t_trim;
    acc(REG_SYSTEM_CONTROL, 16'h0008, 1'b1, 1'b0);
    for (int i = 0; i < TRIM_BYTES; i++)
      acc(REG_TRIM_A_LOW + 16'(i), 16'h00a0 + 16'(i), 1'b1, 1'b0);
    acc(REG_SYSTEM_CONTROL, 16'h0030, 1'b1, 1'b0);
    chk(trimA, 16'ha1a0, "trim a open");
    chk(trimB, {TRIM_RESET, TRIM_RESET}, "trim b shut");
    chk(trimC, {TRIM_RESET, TRIM_RESET}, "trim c shut");
    for (int i = 0; i < TRIM_BYTES; i++)
      acc(REG_TRIM_A_LOW + 16'(i), 16'h00b0 + 16'(i), 1'b1, 1'b0);
    acc(REG_SYSTEM_CONTROL, 16'h0000, 1'b1, 1'b0);
    chk(trimA, 16'ha1a0, "trim a shut");
    chk(trimB, 16'hb3b2, "trim b open");
    chk(trimC, 16'hb5b4, "trim c open");
    $display("test trim done");
  endtask

  task automatic t_cpu;
    acc(REG_SYSTEM_CONTROL, 16'h0001, 1'b1, 1'b0);
    acc(REG_SYSTEM_CONTROL, 16'h0002, 1'b1, 1'b0);
    chkb(pcpuRstn, 1'b1, "protocol cpu released");
    acc(REG_SYSTEM_CONTROL, 16'h0000, 1'b0, 1'b0);
    chkb(halt, 1'b1, "main cpu halted");
    chkb(pcpuRstn, 1'b0, "protocol cpu in reset");
    chk(rv, 16'h0002, "halt reads back");
    $display("test cpu done");
  endtask

  task automatic t_nvm;
    logic [1:0]  ops [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
    logic [15:0] dat [4] = '{16'ha5c3, 16'h1234, 16'h5a5a, 16'h0f0f};
    int          wi [3] = '{0, 2, NVM_WORDS - 1};
    int          n;
    acc(NVM_BASE + 16'h0004, 16'h1111, 1'b1, 1'b0);
    chkb(pj, 1'b1, "change while disabled");
    chkb(busy, 1'b0, "no op while disabled");
    acc(REG_SYSTEM_CONTROL, 16'h0040, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      acc(REG_NVM_CONTROL, 16'(ops[k]), 1'b1, 1'b0);
      acc(NVM_BASE + 16'h0004, dat[k], 1'b1, 1'b0);
      case (ops[k])
        2'h0: mem[2] = dat[k];
        2'h1: mem[2] = NVM_ERASED;
        2'h2: foreach (mem[j]) mem[j] = dat[k];
        default: foreach (mem[j]) mem[j] = NVM_ERASED;
      endcase
      chkb(busy, 1'b1, "busy after start");
      acc(NVM_BASE, 16'h7777, 1'b1, 1'b0);
      chkb(pj, 1'b1, "write while busy");
      acc(NVM_BASE, 16'h0000, 1'b0, 1'b0);
      chkb(pj, 1'b1, "read while busy");
      acc(REG_NVM_CONTROL, 16'h0000, 1'b0, 1'b0);
      chk(rv, {8'h00, 1'b1, 5'h00, ops[k]}, "busy and op select");
      n = 0;
      while (busy !== 1'b0 && n < 300) begin
        @(posedge clock);
        #1;
        n++;
      end
      chkb(done, 1'b1, "done at busy fall");
      @(posedge clock);
      #1;
      chk(16'(lastRun), 16'(OPC + 1), "busy length");
      for (int j = 0; j < 3; j++) begin
        acc(NVM_BASE + 16'(2 * wi[j]), 16'h0000, 1'b0, 1'b0);
        chk(rv, mem[wi[j]], "memory word");
      end
    end
    $display("test nvm done");
  endtask

  task automatic t_ecc;
    logic [1:0] pat [3] = '{2'b01, 2'b10, 2'b11};
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      eccS <= pat[k][0];
      eccD <= pat[k][1];
      @(posedge clock);
      eccS <= 1'b0;
      eccD <= 1'b0;
      acc(REG_USER_STATUS_FLAGS, 16'h0000, 1'b0, 1'b1);
      chk(rv, {8'h00, pat[k], 6'h00}, "error flags");
      acc(REG_USER_STATUS_FLAGS, 16'h0000, 1'b0, 1'b1);
      chk(rv, 16'h0000, "flags cleared");
    end
    $display("test ecc done");
  endtask

  task automatic t_rerun;
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chkb(halt, 1'b0, "halt cleared by reset");
    chk(trimB, {TRIM_RESET, TRIM_RESET}, "trim after reset");
    acc(REG_SYSTEM_CONTROL, 16'h0000, 1'b0, 1'b0);
    chk(rv, {8'h00, CONTROL_RESET}, "control after reset");
    $display("test rerun done");
  endtask

  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset;
    t_modes;
    t_custom;
    t_trim;
    t_cpu;
    t_nvm;
    t_ecc;
    t_rerun;
    results;
  end
endmodule
`default_nettype wire

/* hw/scpb_nvm_array.sv */
// Purpose: Storage array of the nonvolatile memory model.
// Assumes: One write port and one read port on the same clock.
// Notes:   Read data come out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module scpb_nvm_array
  import scpb_pkg::*;
#(
  parameter int WORDS = NVM_WORDS,
  parameter int WIDTH = NVM_WIDTH
) (
  // Clock.
  input  wire logic                     clock,
  // Write port.
  input  wire logic                     writeEn,
  input  wire logic [$clog2(WORDS)-1:0] writeAddr,
  input  wire logic [WIDTH-1:0]         writeData,
  // Read port.
  input  wire logic [$clog2(WORDS)-1:0] readAddr,
  output logic      [WIDTH-1:0]         readData_ff
);

  logic [WIDTH-1:0] store [WORDS];

  always_ff @(posedge clock) begin
    if (writeEn) begin
      store[writeAddr] <= writeData;
    end
  end

  always_ff @(posedge clock) begin
    readData_ff <= store[readAddr];
  end

endmodule
`default_nettype wire

/* hw/scpb_op_timer.sv */
// Purpose: Delay timer for nonvolatile write and erase operations.
// Assumes: Start is ignored while the timer runs.
// Notes:   Busy rises at the edge that takes start and stays COUNT cycles.
`timescale 1ns/1ps
`default_nettype none
module scpb_op_timer
  import scpb_pkg::*;
#(
  parameter int COUNT = NVM_OP_CYCLES
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rstn,
  // Control.
  input  wire logic start,
  output logic      busy_ff
);

  localparam int CW = $clog2(COUNT + 1);

  logic [CW-1:0] count_ff;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_ff <= '0;
      busy_ff  <= 1'b0;
    end else if (!busy_ff && start) begin
      count_ff <= CW'(COUNT - 1);
      busy_ff  <= 1'b1;
    end else if (busy_ff) begin
      if (count_ff == '0) begin
        busy_ff <= 1'b0;
      end else begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* hw/scpb_pkg.sv */
// Purpose: Shared constants and types of the system control port bank.
// Assumes: Byte wide ports on a 16-bit address bus, one 125 MHz clock.
// Notes:   Offsets are byte addresses of the main CPU address space.
package scpb_pkg;

  // Port spaces and windows.
  localparam logic [15:0] SYS_BASE          = 16'he000;
  localparam logic [15:0] SYS_BYTES         = 16'h0030;
  localparam logic [15:0] USER_BASE         = 16'hc000;
  localparam logic [15:0] USER_BYTES        = 16'h0020;
  localparam int          CUSTOM_USER_BYTES = 16;
  localparam int          CUSTOM_SYS_BYTES  = 12;
  localparam logic [15:0] CUSTOM_USER_BASE  = 16'hc020;
  localparam logic [15:0] CUSTOM_SYS_BASE   = 16'he030;

  // Register offsets.
  localparam logic [15:0] REG_SYSTEM_CONTROL    = 16'he000;
  localparam logic [15:0] REG_NVM_CONTROL       = 16'he001;
  localparam logic [15:0] REG_USER_STATUS_FLAGS = 16'hc000;
  localparam logic [15:0] REG_TRIM_A_LOW        = 16'he01c;

  // Nonvolatile memory window.
  localparam logic [15:0] NVM_BASE  = 16'h8000;
  localparam logic [15:0] NVM_BYTES = 16'h00c0;
  localparam int          NVM_WORDS = 96;
  localparam int          NVM_WIDTH = 16;

  // Field positions and trim byte count.
  localparam int CTL_NVM_WE_BIT      = 6;
  localparam int CTL_TRIM_C_WE_BIT   = 5;
  localparam int CTL_TRIM_B_WE_BIT   = 4;
  localparam int CTL_TRIM_A_WE_BIT   = 3;
  localparam int CTL_HALT_BIT        = 1;
  localparam int CTL_PCPU_RESET_BIT  = 0;
  localparam int NVMCTL_BUSY_BIT     = 7;
  localparam int STAT_DOUBLE_ERR_BIT = 7;
  localparam int STAT_SINGLE_ERR_BIT = 6;
  localparam int TRIM_BYTES          = 6;

  // Values after reset and of an erased memory word.
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [1:0]  NVM_OP_RESET  = 2'h0;
  localparam logic [7:0]  TRIM_RESET    = 8'h00;
  localparam logic [15:0] NVM_ERASED    = 16'hffff;

  // Write and erase delay.
  localparam int NVM_OP_TIME_US = 5000;
  localparam int CLOCK_MHZ      = 125;
  localparam int NVM_OP_CYCLES  = NVM_OP_TIME_US * CLOCK_MHZ;

  typedef enum logic [1:0] {
    NVM_WORD_WRITE  = 2'h0,
    NVM_WORD_ERASE  = 2'h1,
    NVM_BLOCK_WRITE = 2'h2,
    NVM_BLOCK_ERASE = 2'h3
  } scpb_nvm_op_type;

  typedef enum logic [1:0] {
    NVM_IDLE,
    NVM_FILL,
    NVM_WAIT
  } scpb_nvm_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        userMode;
  } scpb_bus_req_type;

endpackage

/* hw/scpb_system_control_port_bank.sv */
// Purpose: Protected system control ports, trim banks and nonvolatile control.
// Assumes: Bus requests and error pulses come from logic on the same clock.
// Notes:   Every read answers two cycles after it is taken.
//
// Functional notes
// - Operation select 00 writes one word, 01 erases one word, 10 writes the data to every word.
// - Operation select 11 makes an accepted memory write set every bit of the array to one.
// - Control bit 6 set permits memory changes and clear blocks them.
// - Control bit 5 gates writes to trim bank C.
// - Control bit 4 gates writes to trim bank B.
// - Control bit 3 gates writes to trim bank A.
// - Writing one to control bit 1 halts the main CPU.
// - Control bit 0 drives the reset of the protocol CPU.
// - Status bit 7 reports an uncorrectable double error.
// - Status bit 6 reports a corrected single error.
// - The system port space at 0xE000 is open only with the user-mode bit clear.
// - The user port space at 0xC000 is open only with the user-mode bit set.
// - The decoder keeps 16 custom user bytes and 12 custom system bytes beyond the core map.
// - Unimplemented port addresses read zero and ignore writes.
// - The busy flag is one during a write or erase and its fall raises the done interrupt.
// - Change-enable resets to zero and a change tried while it is zero is cancelled with a protect interrupt.
`timescale 1ns/1ps
`default_nettype none
module scpb_system_control_port_bank
  import scpb_pkg::*;
#(
  parameter int OP_CYCLES = NVM_OP_CYCLES
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             resetn,
  // Main CPU bus.
  input  wire scpb_bus_req_type busReq,
  output logic      [15:0]      rdData_ff,
  output logic                  rdValid_ff,
  output logic                  accessReject_ff,
  // Memory error reports.
  input  wire logic             eccSingleErr,
  input  wire logic             eccDoubleErr,
  // CPU control.
  output logic                  mainCpuHalt_ff,
  output logic                  protocolCpuResetn_ff,
  // Analog trim banks.
  output logic      [15:0]      analogTrimBankA_ff,
  output logic      [15:0]      analogTrimBankB_ff,
  output logic      [15:0]      analogTrimBankC_ff,
  // Nonvolatile memory events.
  output logic                  nvmBusyFlag_ff,
  output logic                  nvmDoneInterrupt_ff,
  output logic                  nvmProtectInterrupt_ff
);

  localparam int AW = $clog2(NVM_WORDS);

  logic               rstSync1_ff;
  logic               rstn_ff;
  logic [7:0]         control_ff;
  scpb_nvm_op_type    nvmOpSelect_ff;
  logic [7:0]         trimByte_ff [TRIM_BYTES];
  logic               doubleErr_ff;
  logic               singleErr_ff;
  scpb_nvm_state_type state_ff;
  scpb_nvm_state_type nxt_state;
  logic [AW-1:0]      fillIdx_ff;
  logic [15:0]        fillData_ff;
  logic               rdPend_ff;
  logic               rdFromNvm_ff;
  logic [7:0]         portData_ff;
  logic [15:0]        nvmReadWord;
  logic               timerBusy;
  logic               inSys;
  logic               inUser;
  logic               inNvm;
  logic               sysOk;
  logic               userOk;
  logic               reject;
  logic               sysWr;
  logic [15:0]        nvmOffset;
  logic [AW-1:0]      nvmIdx;
  logic               nvmWrTry;
  logic               nvmRdTry;
  logic               nvmAccept;
  logic               nvmRefuse;
  logic               memWe;
  logic [AW-1:0]      memWaddr;
  logic [15:0]        memWdata;
  logic [7:0]         nxt_portData;
  logic               nxt_nvmBusy;

  // Reset release through two flip-flops.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstSync1_ff <= 1'b0;
      rstn_ff     <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstn_ff     <= rstSync1_ff;
    end
  end

  // Address decode of the two port spaces and the memory window.
  always_comb begin
    inSys     = (busReq.addr >= SYS_BASE) &&
                (busReq.addr < SYS_BASE + SYS_BYTES + 16'(CUSTOM_SYS_BYTES));
    inUser    = (busReq.addr >= USER_BASE) &&
                (busReq.addr < USER_BASE + USER_BYTES + 16'(CUSTOM_USER_BYTES));
    inNvm     = (busReq.addr >= NVM_BASE) && (busReq.addr < NVM_BASE + NVM_BYTES);
    sysOk     = inSys && !busReq.userMode;
    userOk    = inUser && busReq.userMode;
    reject    = (busReq.wr || busReq.rd) &&
                ((inSys && busReq.userMode) || (inUser && !busReq.userMode));
    sysWr     = busReq.wr && sysOk;
    nvmOffset = busReq.addr - NVM_BASE;
    nvmIdx    = nvmOffset[AW:1];
    nvmWrTry  = busReq.wr && inNvm;
    nvmRdTry  = busReq.rd && inNvm;
    nvmAccept = nvmWrTry && !busReq.userMode && control_ff[CTL_NVM_WE_BIT] &&
                (state_ff == NVM_IDLE);
    nvmRefuse = (nvmWrTry && !nvmAccept) || (nvmRdTry && state_ff != NVM_IDLE);
  end

  // System control register.
  always_ff @(posedge clock or negedge rstn_ff) begin
    if (!rstn_ff) begin
      control_ff <= CONTROL_RESET;
    end else if (sysWr && busReq.addr == REG_SYSTEM_CONTROL) begin
      control_ff <= {1'b0, busReq.wdata[6:3], 1'b0, 1'b0, busReq.wdata[0]};
    end
  end

  always_ff @(posedge clock or negedge rstn_ff) begin
    if (!rstn_ff) begin
      mainCpuHalt_ff <= 1'b0;
    end else if (sysWr && busReq.addr == REG_SYSTEM_CONTROL &&
                 busReq.wdata[CTL_HALT_BIT]) begin
      mainCpuHalt_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn_ff) begin
    if (!rstn_ff) begin
      protocolCpuResetn_ff <= 1'b0;
    end else begin
      protocolCpuResetn_ff <= control_ff[CTL_PCPU_RESET_BIT];
    end
  end

  // Operation select field of the memory control register.
  always_ff @(posedge clock or negedge rstn_ff) begin
    if (!rstn_ff) begin
      nvmOpSelect_ff <= scpb_nvm_op_type'(NVM_OP_RESET);
    end else if (sysWr && busReq.addr == REG_NVM_CONTROL) begin
      nvmOpSelect_ff <= scpb_nvm_op_type'(busReq.wdata[1:0]);
    end
  end

  // Trim bank bytes, each bank gated by its own enable bit.
  for (genvar b = 0; b < TRIM_BYTES; b++) begin : gTrim
    always_ff @(posedge clock or negedge rstn_ff) begin
      if (!rstn_ff) begin
        trimByte_ff[b] <= TRIM_RESET;
      end else if (sysWr && busReq.addr == REG_TRIM_A_LOW + 16'(b) &&
                   control_ff[CTL_TRIM_A_WE_BIT + b / 2]) begin
        trimByte_ff[b] <= busReq.wdata[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    analogTrimBankA_ff <= {trimByte_ff[1], trimByte_ff[0]};
    analogTrimBankB_ff <= {trimByte_ff[3], trimByte_ff[2]};
    analogTrimBankC_ff <= {trimByte_ff[5], trimByte_ff[4]};
  end

  // Error flags stick until the status register is read; a new error wins.
  always_ff @(posedge clock or negedge rstn_ff) begin
    if (!rstn_ff) begin
      doubleErr_ff <= 1'b0;
      singleErr_ff <= 1'b0;
    end else begin
      doubleErr_ff <= eccDoubleErr ||
                      (doubleErr_ff && !(busReq.rd && userOk &&
                                         busReq.addr == REG_USER_STATUS_FLAGS));
      singleErr_ff <= eccSingleErr ||
                      (singleErr_ff && !(busReq.rd && userOk &&
                                         busReq.addr == REG_USER_STATUS_FLAGS));
    end
  end

  // Memory operation sequencer.
  always_comb begin
    nxt_state = state_ff;
    memWe     = 1'b0;
    memWaddr  = fillIdx_ff;
    memWdata  = fillData_ff;
    unique case (state_ff)
      NVM_IDLE: begin
        if (nvmAccept) begin
          nxt_state = NVM_WAIT;
          if (nvmOpSelect_ff == NVM_WORD_WRITE || nvmOpSelect_ff == NVM_WORD_ERASE) begin
            memWe    = 1'b1;
            memWaddr = nvmIdx;
            memWdata = (nvmOpSelect_ff == NVM_WORD_ERASE) ? NVM_ERASED : busReq.wdata;
          end else begin
            nxt_state = NVM_FILL;
          end
        end
      end
      NVM_FILL: begin
        memWe = 1'b1;
        if (fillIdx_ff == AW'(NVM_WORDS - 1)) begin
          nxt_state = NVM_WAIT;
        end
      end
      NVM_WAIT: begin
        if (!timerBusy) begin
          nxt_state = NVM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn_ff) begin
    if (!rstn_ff) begin
      state_ff    <= NVM_IDLE;
      fillIdx_ff  <= '0;
      fillData_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == NVM_IDLE && nvmAccept) begin
        fillIdx_ff  <= '0;
        fillData_ff <= (nvmOpSelect_ff == NVM_BLOCK_ERASE) ? NVM_ERASED : busReq.wdata;
      end else if (state_ff == NVM_FILL) begin
        fillIdx_ff <= fillIdx_ff + 1'b1;
      end
    end
  end

  scpb_nvm_array #(
    .WORDS(NVM_WORDS),
    .WIDTH(NVM_WIDTH)
  ) uArray (
    .clock      (clock),
    .writeEn    (memWe),
    .writeAddr  (memWaddr),
    .writeData  (memWdata),
    .readAddr   (nvmIdx),
    .readData_ff(nvmReadWord)
  );

  scpb_op_timer #(
    .COUNT(OP_CYCLES)
  ) uTimer (
    .clock  (clock),
    .rstn   (rstn_ff),
    .start  (state_ff == NVM_IDLE && nvmAccept),
    .busy_ff(timerBusy)
  );

  assign nxt_nvmBusy = (nxt_state != NVM_IDLE);

  always_ff @(posedge clock or negedge rstn_ff) begin
    if (!rstn_ff) begin
      nvmBusyFlag_ff         <= 1'b0;
      nvmDoneInterrupt_ff    <= 1'b0;
      nvmProtectInterrupt_ff <= 1'b0;
      accessReject_ff        <= 1'b0;
    end else begin
      nvmBusyFlag_ff         <= nxt_nvmBusy;
      nvmDoneInterrupt_ff    <= nvmBusyFlag_ff && !nxt_nvmBusy;
      nvmProtectInterrupt_ff <= nvmRefuse;
      accessReject_ff        <= reject;
    end
  end

  // Port read data; unknown and rejected addresses read zero.
  always_comb begin
    nxt_portData = 8'h00;
    if (sysOk) begin
      if (busReq.addr == REG_SYSTEM_CONTROL) begin
        nxt_portData = {control_ff[7:2], mainCpuHalt_ff, control_ff[0]};
      end else if (busReq.addr == REG_NVM_CONTROL) begin
        nxt_portData = {nvmBusyFlag_ff, 5'h00, nvmOpSelect_ff};
      end else if (busReq.addr >= REG_TRIM_A_LOW &&
                   busReq.addr < REG_TRIM_A_LOW + 16'(TRIM_BYTES)) begin
        nxt_portData = trimByte_ff[busReq.addr[2:0] - 3'h4];
      end
    end else if (userOk && busReq.addr == REG_USER_STATUS_FLAGS) begin
      nxt_portData = {doubleErr_ff, singleErr_ff, 6'h00};
    end
  end

  // Two-stage read answer.
  always_ff @(posedge clock or negedge rstn_ff) begin
    if (!rstn_ff) begin
      rdPend_ff    <= 1'b0;
      rdFromNvm_ff <= 1'b0;
      portData_ff  <= 8'h00;
      rdValid_ff   <= 1'b0;
      rdData_ff    <= 16'h0000;
    end else begin
      rdPend_ff    <= busReq.rd;
      rdFromNvm_ff <= nvmRdTry && state_ff == NVM_IDLE;
      portData_ff  <= nxt_portData;
      rdValid_ff   <= rdPend_ff;
      rdData_ff    <= rdFromNvm_ff ? nvmReadWord : {8'h00, portData_ff};
    end
  end

endmodule
`default_nettype wire
